// *** src/scr_regs.sv ***
// Reference-pulse path and range control registers behind a serial port
`timescale 1ns/1ps
`default_nettype none
module scr_regs (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire scr_pkg::scr_spi_pins_s spi_in,
  output logic sdo_out,
  input wire logic ref_pulse_in,
  input wire logic sample_marker_enable_in,
  input wire logic [scr_pkg::SCR_SAMPLE_W-1:0] sample_in,
  output logic [scr_pkg::SCR_SAMPLE_W-1:0] sample_out,
  input wire logic [23:0] capture_position_in,
  input wire logic capture_position_valid_in,
  output logic ref_event_out,
  output scr_pkg::scr_ctrl_s ctrl_out
);
  // Pin synchronisers: three stages, filtered once stages two and three agree
  logic sclk_filt_reg, cs_filt_reg, sdi_filt_reg, ref_filt_reg;
  logic sclk_filt_next, cs_filt_next, sdi_filt_next, ref_filt_next;

  scr_pin_sync #(.IDLE_LEVEL(1'b0)) u_sync_sclk (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(spi_in.sclk),
    .level_out(sclk_filt_reg),
    .level_next_out(sclk_filt_next)
  );

  scr_pin_sync #(.IDLE_LEVEL(1'b1)) u_sync_cs (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(spi_in.cs_n),
    .level_out(cs_filt_reg),
    .level_next_out(cs_filt_next)
  );

  scr_pin_sync #(.IDLE_LEVEL(1'b0)) u_sync_sdi (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(spi_in.sdi),
    .level_out(sdi_filt_reg),
    .level_next_out(sdi_filt_next)
  );

  scr_pin_sync #(.IDLE_LEVEL(1'b0)) u_sync_ref (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .pin_in(ref_pulse_in),
    .level_out(ref_filt_reg),
    .level_next_out(ref_filt_next)
  );

  logic sclk_rise;
  assign sclk_rise = sclk_filt_next & ~sclk_filt_reg & ~cs_filt_reg;

  // Register storage
  logic [7:0] path_reg, path_next;
  logic [7:0] mode_reg, mode_next;
  logic [15:0] range_reg, range_next;
  logic [23:0] pos_reg, pos_next;

  // Serial engine state
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic hdr_done_reg, hdr_done_next;
  logic rd_reg, rd_next;
  logic [14:0] addr_reg, addr_next;
  logic [15:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic sdo_reg, sdo_next;

  // Unmapped addresses read as zero; reserved bits read back as stored
  function automatic logic [7:0] read_byte(input logic [14:0] a,
                                           input logic [7:0] p,
                                           input logic [7:0] m,
                                           input logic [23:0] ps,
                                           input logic [15:0] r);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      scr_pkg::SCR_ADDR_PATH_CTRL: d = p;
      scr_pkg::SCR_ADDR_MODE_CTRL: d = m;
      scr_pkg::SCR_ADDR_POS_B0: d = ps[7:0];
      scr_pkg::SCR_ADDR_POS_B1: d = ps[15:8];
      scr_pkg::SCR_ADDR_POS_B2: d = ps[23:16];
      scr_pkg::SCR_ADDR_RANGE_B0: d = r[7:0];
      scr_pkg::SCR_ADDR_RANGE_B1: d = r[15:8];
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_byte

  logic [15:0] hdr_word;
  logic [7:0] wr_byte;
  logic [14:0] addr_inc;
  assign hdr_word = {shift_reg[14:0], sdi_filt_next};
  assign wr_byte = hdr_word[7:0];
  assign addr_inc = addr_reg + 15'h0001;

  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    hdr_done_next = hdr_done_reg;
    rd_next = rd_reg;
    addr_next = addr_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    path_next = path_reg;
    mode_next = mode_reg;
    range_next = range_reg;
    pos_next = pos_reg;
    // Status is hardware-written only; serial writes never reach it
    // read-only position
    if (capture_position_valid_in) begin
      pos_next = capture_position_in;
    end
    if (cs_filt_reg) begin
      bit_cnt_next = 5'h00;
      hdr_done_next = 1'b0;
      tx_next = 8'h00;
    end else if (sclk_rise) begin
      shift_next = hdr_word;
      tx_next = {tx_reg[6:0], 1'b0};
      if (!hdr_done_reg) begin
        if (bit_cnt_reg == 5'(scr_pkg::SCR_HDR_BITS - 1)) begin
          hdr_done_next = 1'b1;
          bit_cnt_next = 5'h00;
          rd_next = hdr_word[15];
          addr_next = hdr_word[14:0];
          tx_next = read_byte(hdr_word[14:0], path_reg, mode_reg,
                              pos_reg, range_reg);
        end else begin
          bit_cnt_next = bit_cnt_reg + 5'h01;
        end
      end else if (bit_cnt_reg == 5'(scr_pkg::SCR_BYTE_BITS - 1)) begin
        // Byte complete; streaming continues at the next address
        bit_cnt_next = 5'h00;
        addr_next = addr_inc;
        if (rd_reg) begin
          tx_next = read_byte(addr_inc, path_reg, mode_reg, pos_reg,
                              range_reg);
        end else begin
          unique case (addr_reg)
            scr_pkg::SCR_ADDR_PATH_CTRL: path_next = wr_byte;
            scr_pkg::SCR_ADDR_MODE_CTRL: mode_next = wr_byte;
            scr_pkg::SCR_ADDR_RANGE_B0: range_next[7:0] = wr_byte;
            scr_pkg::SCR_ADDR_RANGE_B1: range_next[15:8] = wr_byte;
            default: path_next = path_reg;
          endcase
        end
      end else begin
        bit_cnt_next = bit_cnt_reg + 5'h01;
      end
    end
    // Registered so the pin never glitches while gate and shift update
    sdo_next = hdr_done_next & rd_next & tx_next[7];
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_cnt_reg <= 5'h00;
      hdr_done_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 15'h0000;
      shift_reg <= 16'h0000;
      tx_reg <= 8'h00;
      sdo_reg <= 1'b0;
      path_reg <= scr_pkg::SCR_RST_PATH_CTRL;
      mode_reg <= scr_pkg::SCR_RST_MODE_CTRL;
      range_reg <= scr_pkg::SCR_RST_RANGE;
      pos_reg <= scr_pkg::SCR_RST_POS;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      hdr_done_reg <= hdr_done_next;
      rd_reg <= rd_next;
      addr_reg <= addr_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      sdo_reg <= sdo_next;
      path_reg <= path_next;
      mode_reg <= mode_next;
      range_reg <= range_next;
      pos_reg <= pos_next;
    end
  end

  assign sdo_out = sdo_reg;

  // Control fields out to the analog and datapath side
  always_comb begin
    ctrl_out.ref_pulse_processor_enable = path_reg[scr_pkg::SCR_BIT_PROC_EN];
    ctrl_out.ref_pulse_receiver_enable = path_reg[scr_pkg::SCR_BIT_RECV_EN];
    ctrl_out.window_fine_step = path_reg[scr_pkg::SCR_BIT_FINE_STEP];
    ctrl_out.capture_delay_select =
      path_reg[scr_pkg::SCR_SEL_MSB:scr_pkg::SCR_SEL_LSB];
    ctrl_out.ref_pulse_as_marker = mode_reg[scr_pkg::SCR_BIT_AS_MARKER];
    ctrl_out.device_clock_dc_receiver_mode =
      mode_reg[scr_pkg::SCR_BIT_DEVCLK_DC];
    ctrl_out.ref_pulse_dc_receiver_mode = mode_reg[scr_pkg::SCR_BIT_REF_DC];
    ctrl_out.ref_pulse_polarity_invert = mode_reg[scr_pkg::SCR_BIT_INVERT];
    ctrl_out.channel_a_range_code = range_reg;
  end

  // Reference pulse datapath
  logic ref_pol;
  logic [scr_pkg::SCR_DELAY_TAPS-1:0] dly_reg, dly_next;
  logic [4:0] tap;
  logic ref_dly, ref_dly_prev_reg, ref_dly_prev_next;
  logic event_reg, event_next;
  logic [scr_pkg::SCR_SAMPLE_W-1:0] samp_reg, samp_next;

  // polarity invert
  // A disabled receiver feeds a quiet line, so no stray edges reach alignment
  assign ref_pol = ctrl_out.ref_pulse_receiver_enable &
                   (ref_filt_reg ^ ctrl_out.ref_pulse_polarity_invert);
  // fine steps halve delay
  // Coarse mode spends two taps per code; fine mode one
  assign tap = ctrl_out.window_fine_step ?
               {1'b0, ctrl_out.capture_delay_select} :
               {ctrl_out.capture_delay_select, 1'b0};
  assign ref_dly = dly_reg[tap];

  always_comb begin
    dly_next = {dly_reg[scr_pkg::SCR_DELAY_TAPS-2:0], ref_pol};
    ref_dly_prev_next = ref_dly;
    event_next = ctrl_out.ref_pulse_processor_enable & ref_dly &
                 ~ref_dly_prev_reg;
    samp_next = sample_in;
    if (ctrl_out.ref_pulse_as_marker && sample_marker_enable_in) begin
      samp_next[0] = ref_dly;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dly_reg <= '0;
      ref_dly_prev_reg <= 1'b0;
      event_reg <= 1'b0;
      samp_reg <= '0;
    end else begin
      dly_reg <= dly_next;
      ref_dly_prev_reg <= ref_dly_prev_next;
      event_reg <= event_next;
      samp_reg <= samp_next;
    end
  end

  assign ref_event_out = event_reg;
  assign sample_out = samp_reg;
endmodule : scr_regs

// Three-flop pin synchroniser; the level moves once stages two and three agree
module scr_pin_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic pin_in,
  output logic level_out,
  output logic level_next_out
);
  localparam int NS = scr_pkg::SCR_SYNC_STAGES;
  logic [NS-1:0] sync_reg, sync_next;
  logic level_reg, level_next;

  always_comb begin
    sync_next = {sync_reg[NS-2:0], pin_in};
    level_next = level_reg;
    // Single-cycle glitches never reach the level
    if (sync_reg[NS-2] == sync_reg[NS-1]) begin
      level_next = sync_reg[NS-1];
    end
  end

  // Reset to the idle level so no false edge follows reset
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_reg <= {NS{IDLE_LEVEL}};
      level_reg <= IDLE_LEVEL;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
  assign level_next_out = level_next;
endmodule : scr_pin_sync
`default_nettype wire

// *** src/scr_pkg.sv ***
// Package for the reference-pulse and range control register bank
package scr_pkg;
  // Byte addresses on the serial control port
  localparam logic [14:0] SCR_ADDR_PATH_CTRL = 15'h0029;
  localparam logic [14:0] SCR_ADDR_MODE_CTRL = 15'h002a;
  localparam logic [14:0] SCR_ADDR_POS_B0 = 15'h002c;
  localparam logic [14:0] SCR_ADDR_POS_B1 = 15'h002d;
  localparam logic [14:0] SCR_ADDR_POS_B2 = 15'h002e;
  localparam logic [14:0] SCR_ADDR_RANGE_B0 = 15'h0030;
  localparam logic [14:0] SCR_ADDR_RANGE_B1 = 15'h0031;
  // Reset values
  localparam logic [7:0] SCR_RST_PATH_CTRL = 8'h00;
  localparam logic [7:0] SCR_RST_MODE_CTRL = 8'h00;
  localparam logic [15:0] SCR_RST_RANGE = 16'ha000;
  localparam logic [23:0] SCR_RST_POS = 24'h000000;
  // Path control fields
  localparam int SCR_BIT_PROC_EN = 6;
  localparam int SCR_BIT_RECV_EN = 5;
  localparam int SCR_BIT_FINE_STEP = 4;
  localparam int SCR_SEL_MSB = 3;
  localparam int SCR_SEL_LSB = 0;
  // Mode control fields
  localparam int SCR_BIT_AS_MARKER = 3;
  localparam int SCR_BIT_DEVCLK_DC = 2;
  localparam int SCR_BIT_REF_DC = 1;
  localparam int SCR_BIT_INVERT = 0;
  // Serial frame: one direction bit, 15 address bits, then data bytes
  localparam int SCR_HDR_BITS = 16;
  localparam int SCR_BYTE_BITS = 8;
  localparam int SCR_SEL_W = 4;
  localparam int SCR_DELAY_TAPS = 31;
  localparam int SCR_SYNC_STAGES = 3;
  localparam int SCR_SAMPLE_W = 12;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } scr_spi_pins_s;

  typedef struct packed {
    logic ref_pulse_receiver_enable;
    logic ref_pulse_processor_enable;
    logic window_fine_step;
    logic [3:0] capture_delay_select;
    logic ref_pulse_as_marker;
    logic device_clock_dc_receiver_mode;
    logic ref_pulse_dc_receiver_mode;
    logic ref_pulse_polarity_invert;
    logic [15:0] channel_a_range_code;
  } scr_ctrl_s;
endpackage : scr_pkg

// *** test/scr_regs_monitor.sv ***
// Assertion checker bound to the reference-pulse register bank
`timescale 1ns/1ps
`default_nettype none
module scr_regs_monitor (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire scr_pkg::scr_spi_pins_s spi_in,
  input wire logic sdo_out,
  input wire logic sample_marker_enable_in,
  input wire logic [scr_pkg::SCR_SAMPLE_W-1:0] sample_in,
  input wire logic [scr_pkg::SCR_SAMPLE_W-1:0] sample_out,
  input wire logic ref_event_out,
  input wire scr_pkg::scr_ctrl_s ctrl_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_rst_path;
    $rose(arst_n_in) |-> !ctrl_out.ref_pulse_processor_enable
      && !ctrl_out.ref_pulse_receiver_enable;
  endproperty
  a_rst_path: assert property (p_rst_path)
    else $error("enables set after reset");
  property p_rst_range;
    $rose(arst_n_in) |-> ctrl_out.channel_a_range_code == 16'ha000;
  endproperty
  a_rst_range: assert property (p_rst_range)
    else $error("range code reset value wrong");
  property p_proc_gate;
    ref_event_out |-> $past(ctrl_out.ref_pulse_processor_enable);
  endproperty
  a_proc_gate: assert property (p_proc_gate)
    else $error("event while processor off");
  property p_event_pulse;
    ref_event_out |=> !ref_event_out;
  endproperty
  a_event_pulse: assert property (p_event_pulse)
    else $error("event longer than one cycle");
  property p_mark_off;
    $past(arst_n_in) && !$past(ctrl_out.ref_pulse_as_marker
      && sample_marker_enable_in) |-> sample_out == $past(sample_in);
  endproperty
  a_mark_off: assert property (p_mark_off)
    else $error("sample altered without marker");
  property p_mark_upper;
    $past(arst_n_in) |-> sample_out[11:1] == $past(sample_in[11:1]);
  endproperty
  a_mark_upper: assert property (p_mark_upper)
    else $error("sample upper bits altered");
  property p_sdo_idle;
    spi_in.cs_n [*8] |-> !sdo_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial output active while deselected");
  // Writes land a few cycles after the last rise, select still low
  property p_ctrl_frame;
    $past(arst_n_in) && $changed(ctrl_out) |-> !$past(spi_in.cs_n, 6);
  endproperty
  a_ctrl_frame: assert property (p_ctrl_frame)
    else $error("control changed outside a frame");
endmodule : scr_regs_monitor
bind scr_regs scr_regs_monitor u_mon (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .spi_in(spi_in), .sdo_out(sdo_out),
  .sample_marker_enable_in(sample_marker_enable_in),
  .sample_in(sample_in), .sample_out(sample_out),
  .ref_event_out(ref_event_out), .ctrl_out(ctrl_out));
`default_nettype wire

// *** test/scr_host.sv ***
// Serial control host model for the register port
`timescale 1ns/1ps
`default_nettype none
module scr_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  output var scr_pkg::scr_spi_pins_s spi_out
);
  // Half period well above the synchroniser delay
  localparam int HALF = 10;
  initial spi_out = 3'b010;
  task automatic xfer(input logic [15:0] hdr, input logic [7:0] wd,
    output logic [7:0] rd);
    logic [23:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    spi_out.cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_out.sdi = sh[i];
      repeat (HALF) @(negedge clk_in);
      if (i < 8) rd[i] = sdo_in;
      spi_out.sclk = 1'b1;
      repeat (HALF) @(negedge clk_in);
      spi_out.sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk_in);
    spi_out.cs_n = 1'b1;
    // Released line shows no stale level
    spi_out.sdi = ~spi_out.sdi;
    repeat (HALF) @(negedge clk_in);
  endtask : xfer
endmodule : scr_host
`default_nettype wire

// *** test/test_scr_regs.sv ***
// Self-checking bench for the reference-pulse register bank
`timescale 1ns/1ps
`default_nettype none
module test_scr_regs;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic ref_pulse_in = 1'b0;
  logic mark_en = 1'b0;
  logic [11:0] sample_in = 12'h5a4;
  logic [23:0] pos = 24'h000000;
  logic pos_valid = 1'b0;
  logic sdo_out;
  logic ref_event_out;
  logic [11:0] sample_out;
  scr_pkg::scr_spi_pins_s spi;
  scr_pkg::scr_ctrl_s ctrl;
  int n_fail = 0;
  int compares = 0;
  int lat0;
  always #2 clk_in = ~clk_in;
  scr_regs uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .spi_in(spi),
    .sdo_out(sdo_out), .ref_pulse_in(ref_pulse_in),
    .sample_marker_enable_in(mark_en), .sample_in(sample_in),
    .sample_out(sample_out), .capture_position_in(pos),
    .capture_position_valid_in(pos_valid),
    .ref_event_out(ref_event_out), .ctrl_out(ctrl));
  scr_host u_host (.clk_in(clk_in), .sdo_in(sdo_out), .spi_out(spi));
  task automatic test_done;
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer({1'b0, a}, d, q);
  endtask : wr
  task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_host.xfer({1'b1, a}, 8'h00, q);
    chk(24'(q), 24'(exp));
  endtask : rdc
  // Cycles from a pulse edge to the event, 100 when none
  task automatic lat(output int n);
    ref_pulse_in = ~ref_pulse_in;
    n = 0;
    while (n < 100 && ref_event_out !== 1'b1) begin
      @(negedge clk_in);
      n++;
    end
    ref_pulse_in = ~ref_pulse_in;
    repeat (60) @(negedge clk_in);
  endtask : lat
  task automatic t_events;
    int n;
    wr(15'h029, 8'h20);
    wr(15'h029, 8'h60);
    chk(24'(ctrl.ref_pulse_receiver_enable), 24'h1);
    lat(lat0);
    chk(24'(lat0 < 100), 24'h1);
    wr(15'h029, 8'h62);
    lat(n);
    chk(24'(n), 24'(lat0 + 4));
    wr(15'h029, 8'h72);
    lat(n);
    chk(24'(n), 24'(lat0 + 2));
    wr(15'h029, 8'h20);
    lat(n);
    chk(24'(n), 24'h000064);
    wr(15'h029, 8'h60);
    ref_pulse_in = 1'b1;
    repeat (60) @(negedge clk_in);
    wr(15'h02a, 8'h01);
    lat(n);
    chk(24'(n), 24'(lat0));
    wr(15'h02a, 8'h08);
    mark_en = 1'b1;
    repeat (60) @(negedge clk_in);
    chk(24'(sample_out), 24'h0005a5);
    mark_en = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(24'(sample_out), 24'h0005a4);
    ref_pulse_in = 1'b0;
  endtask : t_events
  task automatic t_regs;
    chk(24'(ctrl.channel_a_range_code), 24'h00a000);
    rdc(15'h029, 8'h00);
    rdc(15'h031, 8'ha0);
    pos = 24'h123456;
    pos_valid = 1'b1;
    @(negedge clk_in);
    pos_valid = 1'b0;
    pos = 24'hfedcba;
    rdc(15'h02c, 8'h56);
    rdc(15'h02e, 8'h12);
    wr(15'h02d, 8'hff);
    rdc(15'h02d, 8'h34);
    rdc(15'h040, 8'h00);
    wr(15'h02a, 8'h06);
    rdc(15'h02a, 8'h06);
    chk(24'(ctrl.device_clock_dc_receiver_mode), 24'h1);
    chk(24'(ctrl.ref_pulse_dc_receiver_mode), 24'h1);
    wr(15'h031, 8'h20);
    chk(24'(ctrl.channel_a_range_code), 24'h002000);
    wr(15'h030, 8'h01);
    rdc(15'h030, 8'h01);
    chk(24'(ctrl.channel_a_range_code), 24'h002001);
    arst_n_in = 1'b0;
    @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (8) @(negedge clk_in);
    chk(24'(ctrl.channel_a_range_code), 24'h00a000);
    chk(24'(ctrl.device_clock_dc_receiver_mode), 24'h0);
  endtask : t_regs
  initial begin
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (8) @(negedge clk_in);
    t_regs;
    t_events;
    test_done;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    test_done;
  end
endmodule : test_scr_regs
`default_nettype wire
